// [asr_defs.svh]
// Purpose: offsets, field positions, reset values and timing counts of the setup bank
// Assumes: 6-bit register addresses, 8-bit register data
// Notes:   definitions only, included by bare name
`ifndef ASR_DEFS_SVH
`define ASR_DEFS_SVH

// ----------------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------------
`define ASR_OFS_POWER_SAMPLING   6'h01
`define ASR_OFS_OUTPUT_REFERENCE 6'h02
`define ASR_OFS_CLAMP_TIMING     6'h03
`define ASR_OFS_DEVICE_RESET     6'h04
`define ASR_OFS_COLOUR_RESET     6'h05

// ----------------------------------------------------------------------------
// reset values and writable-bit masks (reserved bits read zero)
// ----------------------------------------------------------------------------
`define ASR_RST_POWER_SAMPLING   8'h03
`define ASR_RST_OUTPUT_REFERENCE 8'h20
`define ASR_RST_CLAMP_TIMING     8'h1f
`define ASR_MSK_POWER_SAMPLING   8'h7f
`define ASR_MSK_OUTPUT_REFERENCE 8'hef
`define ASR_MSK_CLAMP_TIMING     8'hff

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define ASR_PS_ENABLE    0
`define ASR_PS_CDS       1
`define ASR_PS_MONO      2
`define ASR_PS_SELECTIVE_POWERDOWN     3
`define ASR_PS_OFFSET    4
`define ASR_PS_MAX_SPEED_MODE_FLAG     6
`define ASR_OR_FORMAT    0
`define ASR_OR_INVERT    2
`define ASR_OR_EXTREF    3
`define ASR_OR_RANGE     5
`define ASR_OR_LATENCY   6
`define ASR_CT_DACCODE   0
`define ASR_CT_SHIFT     4
`define ASR_CT_PICK      6

// ----------------------------------------------------------------------------
// ADC period counts in master clock periods, latency field codes in added ADC periods
// ----------------------------------------------------------------------------
`define ASR_ADC_MCLK_NORMAL 2'h2
`define ASR_ADC_MCLK_MODE3  2'h3
`define ASR_LAT_ADD_TWO     2'h2
`define ASR_LAT_ADD_THREE   2'h3

`endif

// [asr_pkg.sv]
// Purpose: types shared by the setup bank and its colour counter
// Assumes: nothing
// Notes:   constants live in asr_defs.svh
package asr_pkg;

	// auto-cycle colour position
	typedef enum logic [1:0] {colour_red, colour_green, colour_blue} asr_colour_t;

	// colour counter state
	typedef struct packed {
		asr_colour_t colour;
	} asr_cyc_state_t;

	// setup bank state
	typedef struct packed {
		logic [7:0] power_sampling;
		logic [7:0] output_reference;
		logic [7:0] clamp_timing;
		logic [7:0] rdata;
		logic       full_pd;
		logic [3:0] blk_dis;
		logic       cds;
		logic       mono;
		logic       ofs_pos;
		logic       ofs_neg;
		logic       max_speed;
		logic       fmt_par;
		logic       fmt_byte;
		logic       fmt_nib;
		logic       invert;
		logic       dac_pd;
		logic       ref_oe;
		logic       dac_rng;
		logic [3:0] dac_code;
		logic [1:0] adc_period;
		logic [3:0] lat_mclk;
		logic       shift_adv;
		logic [1:0] shift_ret;
		logic [1:0] pick;
		logic       green_dis;
		logic       blue_dis;
		logic       dev_rst;
		logic [1:0] acyc_sync;
		logic       acyc_prev;
	} asr_state_t;

endpackage

// [asr_colour_cycle.sv]
// Purpose: auto-cycle colour counter, red then green then blue then red
// Assumes: advance and clear are one-cycle pulses on mclk
// Notes:   clear wins over advance
`timescale 1ns/10ps

module asr_colour_cycle (
	// clock and reset
	input  wire logic                mclk,
	input  wire logic                rst_n,
	input  wire logic                clk_en,
	// control
	input  wire logic                clear,
	input  wire logic                advance,
	// position
	output asr_pkg::asr_colour_t     colour_r
);
	import asr_pkg::*;

	asr_cyc_state_t s_r;
	asr_cyc_state_t s_nxt;

	// next position
	always_comb begin
		s_nxt = s_r;
		if (clk_en) begin
			if (clear) begin
				s_nxt.colour = colour_red;
			end else if (advance) begin
				case (s_r.colour)
					colour_red:   s_nxt.colour = colour_green;
					colour_green: s_nxt.colour = colour_blue;
					colour_blue:  s_nxt.colour = colour_red;
					default:      s_nxt.colour = colour_red;
				endcase
			end
		end
	end

	// state register
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			s_r <= '{colour: colour_red};
		end else begin
			s_r <= s_nxt;
		end
	end

	assign colour_r = s_r.colour;

	// a clear with clk_en high always lands on red one edge later
	clear_red_a: assert property (@(posedge mclk) disable iff (!rst_n)
		(clk_en && clear) |=> (s_r.colour == colour_red))
		else $error("colour counter not red after clear");

endmodule

// [asr_setup_bank.sv]
// Purpose: setup register bank of a three-channel imaging front end
// Assumes: register strobes come from the serial decoder on mclk
// Notes:   every control output is registered, one edge after the write
`timescale 1ns/10ps
`include "asr_defs.svh"

module asr_setup_bank #(
	parameter int ADDR_W = 6,
	parameter int DATA_W = 8
) (
	// clock, reset, enable
	input  wire logic                mclk,
	input  wire logic                rstn,
	input  wire logic                clk_en,
	// register access from the serial decoder
	input  wire logic                wr_en,
	input  wire logic                rd_en,
	input  wire logic [ADDR_W-1:0]   addr,
	input  wire logic [DATA_W-1:0]   wdata,
	output logic      [DATA_W-1:0]   rdata_r,
	// surrounding controls
	input  wire logic                sequential_colour_enable,
	input  wire logic [3:0]          block_disable_field,
	input  wire logic                mode_three,
	input  wire logic                acyc_pin,
	// power and sampling
	output logic                     full_powerdown_r,
	output logic      [3:0]          block_disable_r,
	output logic                     cds_enable_r,
	output logic                     mono_enable_r,
	output logic                     offset_pos_fs_r,
	output logic                     offset_neg_fs_r,
	output logic                     max_speed_mode_flag_r,
	// output formatting
	output logic                     format_parallel_r,
	output logic                     format_byte_r,
	output logic                     format_nibble_r,
	output logic                     output_invert_r,
	output logic      [3:0]          latency_mclk_r,
	output logic      [1:0]          adc_period_mclk_r,
	// reference DAC
	output logic                     reference_dac_powerdown_r,
	output logic                     reference_level_pin_oe_r,
	output logic                     reference_dac_range_r,
	output logic      [3:0]          reference_dac_code_r,
	// sampling timing and channels
	output logic                     reset_shift_advance_r,
	output logic      [1:0]          reset_shift_retard_r,
	output logic      [1:0]          mono_input_pick_r,
	output logic                     green_amp_disable_r,
	output logic                     blue_amp_disable_r,
	// strobes and counter
	output logic                     device_reset_r,
	output asr_pkg::asr_colour_t     colour_pos_r
);
	import asr_pkg::*;

	// ------------------------------------------------------------------------
	// parameter checks
	// ------------------------------------------------------------------------
	// the register layout is fixed at six address and eight data bits
	if (ADDR_W != 6 || DATA_W != 8) begin : g_bad_width
		$error("asr_setup_bank needs ADDR_W 6 and DATA_W 8");
	end

	// ------------------------------------------------------------------------
	// reset release
	// ------------------------------------------------------------------------
	logic [1:0] rst_sync_r;
	logic       rst_n_r;

	// async assert, two-flop release so nothing sees a ragged deassertion
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			rst_sync_r <= 2'h0;
		end else begin
			rst_sync_r <= {rst_sync_r[0], 1'h1};
		end
	end
	assign rst_n_r = rst_sync_r[1];

	// ------------------------------------------------------------------------
	// state and decode
	// ------------------------------------------------------------------------
	asr_state_t s_r;
	asr_state_t s_nxt;
	logic       wr_ps;
	logic       wr_or;
	logic       wr_ct;
	logic       wr_dev_rst;
	logic       wr_cyc_rst;
	logic       cyc_clear;
	logic       cyc_advance;

	// write decode, qualified by the clock enable
	assign wr_ps      = clk_en && wr_en && (addr == `ASR_OFS_POWER_SAMPLING);
	assign wr_or      = clk_en && wr_en && (addr == `ASR_OFS_OUTPUT_REFERENCE);
	assign wr_ct      = clk_en && wr_en && (addr == `ASR_OFS_CLAMP_TIMING);
	assign wr_dev_rst = clk_en && wr_en && (addr == `ASR_OFS_DEVICE_RESET);
	assign wr_cyc_rst = clk_en && wr_en && (addr == `ASR_OFS_COLOUR_RESET);

	// cycle counter clear
	// the data value is ignored; a device reset clears the counter too
	assign cyc_clear   = wr_cyc_rst || wr_dev_rst;
	// counter steps on a rising pin edge, only meaningful line by line
	assign cyc_advance = sequential_colour_enable && s_r.acyc_sync[1] && !s_r.acyc_prev;

	// ------------------------------------------------------------------------
	// next state
	// ------------------------------------------------------------------------
	always_comb begin
		s_nxt = s_r;
		if (clk_en) begin
			// pin synchroniser; only stage 1 feeds the edge detector
			s_nxt.acyc_sync = {s_r.acyc_sync[0], acyc_pin};
			s_nxt.acyc_prev = s_r.acyc_sync[1];
			s_nxt.dev_rst   = 1'h0;

			// register writes, reserved bits held at zero
			if (wr_ps) begin
				s_nxt.power_sampling = wdata & `ASR_MSK_POWER_SAMPLING;
			end
			if (wr_or) begin
				s_nxt.output_reference = wdata & `ASR_MSK_OUTPUT_REFERENCE;
			end
			if (wr_ct) begin
				s_nxt.clamp_timing = wdata & `ASR_MSK_CLAMP_TIMING;
			end
			if (wr_dev_rst) begin
				s_nxt.power_sampling   = `ASR_RST_POWER_SAMPLING;
				s_nxt.output_reference = `ASR_RST_OUTPUT_REFERENCE;
				s_nxt.clamp_timing     = `ASR_RST_CLAMP_TIMING;
				s_nxt.rdata            = 8'h00;
				s_nxt.dev_rst          = 1'h1;
			end

			// readback; strobe locations and holes read zero
			if (rd_en && !wr_dev_rst) begin
				case (addr)
					`ASR_OFS_POWER_SAMPLING:   s_nxt.rdata = s_r.power_sampling;
					`ASR_OFS_OUTPUT_REFERENCE: s_nxt.rdata = s_r.output_reference;
					`ASR_OFS_CLAMP_TIMING:     s_nxt.rdata = s_r.clamp_timing;
					default:                   s_nxt.rdata = 8'h00;
				endcase
			end

			// global power-down, ignored under selective control
			s_nxt.full_pd = !s_nxt.power_sampling[`ASR_PS_SELECTIVE_POWERDOWN]
				&& !s_nxt.power_sampling[`ASR_PS_ENABLE];
			// individual disables only under selective control
			s_nxt.blk_dis = s_nxt.power_sampling[`ASR_PS_SELECTIVE_POWERDOWN] ? block_disable_field : 4'h0;
			s_nxt.cds = s_nxt.power_sampling[`ASR_PS_CDS];
			s_nxt.mono = s_nxt.power_sampling[`ASR_PS_MONO] || sequential_colour_enable;
			case (s_nxt.power_sampling[`ASR_PS_OFFSET +: 2])
				2'h2:    {s_nxt.ofs_pos, s_nxt.ofs_neg} = 2'h2;
				2'h3:    {s_nxt.ofs_pos, s_nxt.ofs_neg} = 2'h1;
				default: {s_nxt.ofs_pos, s_nxt.ofs_neg} = 2'h0;
			endcase
			// max-speed flag passed to the timing logic
			s_nxt.max_speed = s_nxt.power_sampling[`ASR_PS_MAX_SPEED_MODE_FLAG];

			case (s_nxt.output_reference[`ASR_OR_FORMAT +: 2])
				2'h0:    {s_nxt.fmt_par, s_nxt.fmt_byte, s_nxt.fmt_nib} = 3'h4;
				2'h3:    {s_nxt.fmt_par, s_nxt.fmt_byte, s_nxt.fmt_nib} = 3'h1;
				default: {s_nxt.fmt_par, s_nxt.fmt_byte, s_nxt.fmt_nib} = 3'h2;
			endcase
			s_nxt.invert = s_nxt.output_reference[`ASR_OR_INVERT];
			// external reference floats the DAC output
			s_nxt.dac_pd = s_nxt.output_reference[`ASR_OR_EXTREF];
			s_nxt.ref_oe = !s_nxt.output_reference[`ASR_OR_EXTREF];
			s_nxt.dac_rng = s_nxt.output_reference[`ASR_OR_RANGE];
			s_nxt.adc_period = mode_three ? `ASR_ADC_MCLK_MODE3 : `ASR_ADC_MCLK_NORMAL;
			// extra latency in master clocks; code 01 is taken as minimum
			case (s_nxt.output_reference[`ASR_OR_LATENCY +: 2])
				`ASR_LAT_ADD_TWO:   s_nxt.lat_mclk = mode_three ? 4'h6 : 4'h4;
				`ASR_LAT_ADD_THREE: s_nxt.lat_mclk = mode_three ? 4'h9 : 4'h6;
				default:            s_nxt.lat_mclk = 4'h0;
			endcase

			s_nxt.dac_code = s_nxt.clamp_timing[`ASR_CT_DACCODE +: 4];
			// reset-sample shift, code 01 is nominal
			case (s_nxt.clamp_timing[`ASR_CT_SHIFT +: 2])
				2'h0:    {s_nxt.shift_adv, s_nxt.shift_ret} = 3'h4;
				2'h2:    {s_nxt.shift_adv, s_nxt.shift_ret} = 3'h1;
				2'h3:    {s_nxt.shift_adv, s_nxt.shift_ret} = 3'h2;
				default: {s_nxt.shift_adv, s_nxt.shift_ret} = 3'h0;
			endcase
			// mono pick, forced to red line by line
			s_nxt.pick = sequential_colour_enable ? 2'h0 : s_nxt.clamp_timing[`ASR_CT_PICK +: 2];
			// save power on the unused amplifiers
			s_nxt.green_dis = sequential_colour_enable;
			s_nxt.blue_dis  = sequential_colour_enable;
		end
	end

	// ------------------------------------------------------------------------
	// state register
	// ------------------------------------------------------------------------
	// reset image matches what the defaults decode to
	always_ff @(posedge mclk or negedge rst_n_r) begin
		if (!rst_n_r) begin
			s_r                  <= '0;
			s_r.power_sampling   <= `ASR_RST_POWER_SAMPLING;
			s_r.output_reference <= `ASR_RST_OUTPUT_REFERENCE;
			s_r.clamp_timing     <= `ASR_RST_CLAMP_TIMING;
			s_r.cds              <= 1'h1;
			s_r.fmt_par          <= 1'h1;
			s_r.ref_oe           <= 1'h1;
			s_r.dac_rng          <= 1'h1;
			s_r.dac_code         <= 4'hf;
			s_r.adc_period       <= `ASR_ADC_MCLK_NORMAL;
		end else begin
			s_r <= s_nxt;
		end
	end

	// ------------------------------------------------------------------------
	// colour counter
	// ------------------------------------------------------------------------
	asr_colour_cycle u_cycle (
		.mclk     (mclk),
		.rst_n    (rst_n_r),
		.clk_en   (clk_en),
		.clear    (cyc_clear),
		.advance  (cyc_advance),
		.colour_r (colour_pos_r)
	);

	// ------------------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------------------
	assign rdata_r                   = s_r.rdata;
	assign full_powerdown_r          = s_r.full_pd;
	assign block_disable_r           = s_r.blk_dis;
	assign cds_enable_r              = s_r.cds;
	assign mono_enable_r             = s_r.mono;
	assign offset_pos_fs_r           = s_r.ofs_pos;
	assign offset_neg_fs_r           = s_r.ofs_neg;
	assign max_speed_mode_flag_r     = s_r.max_speed;
	assign format_parallel_r         = s_r.fmt_par;
	assign format_byte_r             = s_r.fmt_byte;
	assign format_nibble_r           = s_r.fmt_nib;
	assign output_invert_r           = s_r.invert;
	assign latency_mclk_r            = s_r.lat_mclk;
	assign adc_period_mclk_r         = s_r.adc_period;
	assign reference_dac_powerdown_r = s_r.dac_pd;
	assign reference_level_pin_oe_r  = s_r.ref_oe;
	assign reference_dac_range_r     = s_r.dac_rng;
	assign reference_dac_code_r      = s_r.dac_code;
	assign reset_shift_advance_r     = s_r.shift_adv;
	assign reset_shift_retard_r      = s_r.shift_ret;
	assign mono_input_pick_r         = s_r.pick;
	assign green_amp_disable_r       = s_r.green_dis;
	assign blue_amp_disable_r        = s_r.blue_dis;
	assign device_reset_r            = s_r.dev_rst;

	// ------------------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------------------
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rst_n_r);

	global_pd_a: assert property (
		(wr_ps && !wdata[3]) |=> (full_powerdown_r == !$past(wdata[0])))
		else $error("global power-down does not follow enable bit");
	cds_mode_a: assert property (
		wr_ps |=> (cds_enable_r == $past(wdata[1])))
		else $error("sampling mode does not follow write");
	sel_disable_a: assert property (
		(wr_ps && !wdata[3]) |=> (block_disable_r == 4'h0))
		else $error("block disables applied without selective control");
	format_one_a: assert property (
		wr_or |=> (format_parallel_r == ($past(wdata[1:0]) == 2'h0)
			&& format_nibble_r == ($past(wdata[1:0]) == 2'h3)
			&& $countones({format_parallel_r, format_byte_r, format_nibble_r}) == 1))
		else $error("output format does not follow write");
	ext_ref_a: assert property (
		reference_dac_powerdown_r |-> !reference_level_pin_oe_r)
		else $error("reference pin driven while DAC powered down");
	latency_mode3_a: assert property (
		(clk_en && !wr_en && s_r.output_reference[7:6] == 2'h3 && mode_three)
		|=> (latency_mclk_r == 4'h9))
		else $error("mode 3 latency not nine master clocks");
	soft_reset_a: assert property (
		wr_dev_rst |=> (s_r.power_sampling == `ASR_RST_POWER_SAMPLING
			&& s_r.output_reference == `ASR_RST_OUTPUT_REFERENCE
			&& s_r.clamp_timing == `ASR_RST_CLAMP_TIMING && device_reset_r))
		else $error("device reset did not restore defaults");
	cycle_clear_a: assert property (
		wr_cyc_rst |=> (colour_pos_r == colour_red))
		else $error("cycle reset did not return to red");
	line_force_a: assert property (
		(clk_en && sequential_colour_enable) |=> (mono_enable_r && mono_input_pick_r == 2'h0
			&& green_amp_disable_r && blue_amp_disable_r))
		else $error("line-by-line forcing missing");
	// the host leaves one idle edge between a write and the next read
	readback_a: assert property (
		(wr_ps ##1 !wr_en ##1 (clk_en && rd_en && !wr_en && addr == `ASR_OFS_POWER_SAMPLING))
		|=> (rdata_r == ($past(wdata, 3) & `ASR_MSK_POWER_SAMPLING)))
		else $error("readback differs from last write");

	soft_reset_c: cover property (wr_dev_rst ##1 device_reset_r);
	line_mode_c: cover property (sequential_colour_enable ##1 mono_enable_r);
	cycle_step_c: cover property (cyc_advance ##1 colour_pos_r == colour_green);
	max_speed_c: cover property (wr_ps && wdata[6] ##1 max_speed_mode_flag_r);

endmodule

// [asr_host_model.sv]
// Purpose: host side of the register port, one byte per access
// Assumes: requests change on the falling edge of mclk
// Notes:   released address and data are inverted, never left stale
`timescale 1ns/10ps

module asr_host_model (
	// clock
	input  wire logic       mclk,
	// register port
	output logic            wr_en,
	output logic            rd_en,
	output logic      [5:0] addr,
	output logic      [7:0] wdata,
	input  wire logic [7:0] rdata_r
);
	// idle bus at time zero
	initial begin
		wr_en = 1'b0;
		rd_en = 1'b0;
		addr  = 6'h3f;
		wdata = 8'h00;
	end

	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		@(negedge mclk);
		wr_en = 1'b1;
		addr  = a;
		wdata = d;
		@(negedge mclk);
		wr_en = 1'b0;
		addr  = ~a;
		wdata = ~d;
	endtask

	// read by address, data valid one edge later
	task automatic rd(input logic [5:0] a, output logic [7:0] d);
		@(negedge mclk);
		rd_en = 1'b1;
		addr  = a;
		@(negedge mclk);
		rd_en = 1'b0;
		addr  = ~a;
		d     = rdata_r;
	endtask
endmodule

// [afe_setup_register_bank_bench.sv]
// Purpose: self-checking bench for the setup register bank
// Assumes: host model drives the register port on falling edges
// Notes:   expected controls come from an integer copy of the bank
`timescale 1ns/10ps

module afe_setup_register_bank_bench;
	import asr_pkg::*;
	logic        mclk, rstn, clk_en, seq, m3, acyc, dev_rst;
	logic [3:0]  bdf;
	logic        wr_en, rd_en;
	logic [5:0]  addr;
	logic [7:0]  wdata, rdata_r, rv, d;
	wire  [33:0] got;
	asr_colour_t col;
	int          fails, n_compared, ra, colm;
	int          mreg[1:3];
	int          msk[1:3] = '{'h7f, 'hef, 'hff};
	int          dflt[1:3] = '{'h03, 'h20, 'h1f};

	asr_host_model host (.mclk(mclk), .wr_en(wr_en), .rd_en(rd_en), .addr(addr),
		.wdata(wdata), .rdata_r(rdata_r));

	asr_setup_bank dut (.mclk(mclk), .rstn(rstn), .clk_en(clk_en), .wr_en(wr_en),
		.rd_en(rd_en), .addr(addr), .wdata(wdata), .rdata_r(rdata_r),
		.sequential_colour_enable(seq), .block_disable_field(bdf),
		.mode_three(m3), .acyc_pin(acyc), .full_powerdown_r(got[33]),
		.block_disable_r(got[32:29]), .cds_enable_r(got[28]), .mono_enable_r(got[27]),
		.offset_pos_fs_r(got[26]), .offset_neg_fs_r(got[25]),
		.max_speed_mode_flag_r(got[24]), .format_parallel_r(got[23]),
		.format_byte_r(got[22]), .format_nibble_r(got[21]), .output_invert_r(got[20]),
		.latency_mclk_r(got[19:16]), .adc_period_mclk_r(got[15:14]),
		.reference_dac_powerdown_r(got[13]), .reference_level_pin_oe_r(got[12]),
		.reference_dac_range_r(got[11]), .reference_dac_code_r(got[10:7]),
		.reset_shift_advance_r(got[6]), .reset_shift_retard_r(got[5:4]),
		.mono_input_pick_r(got[3:2]), .green_amp_disable_r(got[1]),
		.blue_amp_disable_r(got[0]), .device_reset_r(dev_rst), .colour_pos_r(col));

	// expected decoded controls from the register copy and side inputs
	function automatic logic [33:0] expv();
		logic [7:0] a, b, c;
		a = mreg[1][7:0];
		b = mreg[2][7:0];
		c = mreg[3][7:0];
		return {~a[3] & ~a[0], a[3] ? bdf : 4'h0, a[1], a[2] | seq, a[5:4] == 2'h2,
			a[5:4] == 2'h3, a[6], b[1:0] == 2'h0, b[1] ^ b[0], &b[1:0], b[2],
			b[7:6] == 2'h2 ? (m3 ? 4'h6 : 4'h4) : b[7:6] == 2'h3 ? (m3 ? 4'h9 : 4'h6) : 4'h0,
			m3 ? 2'h3 : 2'h2, b[3], ~b[3], b[5], c[3:0], c[5:4] == 2'h0,
			c[5:4] == 2'h2 ? 2'h1 : c[5:4] == 2'h3 ? 2'h2 : 2'h0,
			seq ? 2'h0 : c[7:6], seq, seq};
	endfunction

	task automatic chk_byte(input logic [7:0] g, input logic [7:0] e);
		n_compared++;
		if (g !== e) begin
			fails++;
			$display("[FAIL] t=%0t got %h exp %h", $time, g, e);
		end
	endtask

	task automatic chk_ctl(input logic [33:0] g, input logic [33:0] e);
		n_compared++;
		if (g !== e) begin
			fails++;
			$display("[FAIL] t=%0t got %h exp %h", $time, g, e);
		end
	endtask

	task automatic give_verdict();
		$display("compared %0d mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// 50 ns master clock
	initial begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end

	// watchdog, far beyond the few hundred cycles the tests need
	initial begin
		#(50 * 3000);
		fails++;
		give_verdict();
	end

	// ----
	// main sequence
	// ----
	initial begin
		rstn = 1'b0;
		clk_en = 1'b1;
		seq = 1'b0;
		m3 = 1'b0;
		acyc = 1'b0;
		bdf = 4'h0;
		colm = 0;
		mreg = dflt;
		void'($urandom(32'h6437));
		repeat (16) @(negedge mclk);
		rstn = 1'b1;
		repeat (3) @(negedge mclk);
		chk_ctl(got, expv());
		host.wr(6'h04, 8'h5a);
		host.wr(6'h2a, 8'hff);
		for (int a = 1; a < 8; a++) begin
			host.rd(a[5:0], rv);
			chk_byte(rv, a < 4 ? mreg[a][7:0] : 8'h00);
		end
		chk_ctl(got, expv());
		$display("test defaults done");
		// bytes 00, 55, aa, ff (7f in place of ff at register 3) into each register first, then random contents and seq
		for (int i = 0; i < 32; i++) begin
			ra = i < 12 ? i % 3 + 1 : 1 + $urandom % 3;
			d = i < 12 ? 8'((i / 3) * 'h55) : 8'($urandom);
			// host keeps off the reserved mono pick code
			if (ra == 3 && d[7:6] == 2'h3)
				d[7] = 1'b0;
			seq = i < 12 ? 1'b0 : 1'($urandom);
			m3 = 1'($urandom);
			bdf = 4'($urandom);
			host.wr(ra[5:0], d);
			mreg[ra] = d & msk[ra];
			host.rd(ra[5:0], rv);
			chk_byte(rv, mreg[ra][7:0]);
			chk_ctl(got, expv());
		end
		// disabled clock refuses a write
		clk_en = 1'b0;
		host.wr(6'h01, 8'h7f & ~mreg[1][7:0]);
		clk_en = 1'b1;
		chk_ctl(got, expv());
		$display("test fields done");
		seq = 1'b1;
		for (int i = 0; i < 3; i++) begin
			@(negedge mclk);
			acyc = 1'b1;
			repeat (2) @(negedge mclk);
			acyc = 1'b0;
			repeat (6) @(negedge mclk);
			colm = (colm + 1) % 3;
			if (i == 1)
				chk_byte({6'h0, col}, colm[7:0]);
			if (i == 1)
				host.wr(6'h05, 8'($urandom));
			if (i == 1)
				colm = 0;
		end
		chk_byte({6'h0, col}, 8'h01);
		host.wr(6'h04, 8'($urandom));
		chk_byte({7'h0, dev_rst}, 8'h01);
		@(negedge mclk);
		chk_byte({7'h0, dev_rst}, 8'h00);
		chk_byte({6'h0, col}, 8'h00);
		mreg = dflt;
		chk_ctl(got, expv());
		$display("test counter and reset done");
		give_verdict();
	end
endmodule
